// ---- shared/ssl_pkg.sv ----
/*
  ssl_pkg: constants and types for the subsystem identity serial loader.
  Assumes a 40 MHz core clock and a two-wire EEPROM with pull-ups on both lines.
*/
package ssl_pkg;
  // configuration space offsets (byte addresses, function 0 and 1)
  localparam logic [7:0] IDENT_OFS = 8'h40;
  localparam logic [7:0] SYSCTL_OFS = 8'h80;
  localparam logic [7:0] STATUS_OFS = 8'h85;
  localparam logic [7:0] STATUS_DW_OFS = {STATUS_OFS[7:2], 2'b00};
  localparam int STATUS_LANE = int'(STATUS_OFS[1:0]);
  // field positions
  localparam int LOCK_BIT = 5;
  localparam int PRESENT_BIT = 2;
  localparam int ERR_BIT = 1;
  localparam int BUSY_BIT = 0;
  // reset values
  localparam logic [31:0] SYSCTL_RST = 32'h0000_0020;
  localparam logic [31:0] IDENT_RST = 32'h0000_0000;
  // eeprom addressing
  localparam logic [6:0] EE_DEV_ADDR = 7'h50;
  localparam logic [7:0] EE_WORD_ADDR = 8'h00;
  localparam int EE_BYTES = 4;
  // sequence steps
  localparam logic [3:0] STEP_START1 = 4'h0;
  localparam logic [3:0] STEP_DEV_WR = 4'h1;
  localparam logic [3:0] STEP_WORD = 4'h2;
  localparam logic [3:0] STEP_START2 = 4'h3;
  localparam logic [3:0] STEP_DEV_RD = 4'h4;
  localparam logic [3:0] STEP_DATA0 = 4'h5;
  localparam logic [3:0] STEP_STOP = 4'h9;
  localparam logic [3:0] ACK_SLOT = 4'h8;
  // timing
  localparam int CLK_NS = 25;
  localparam int SCL_HALF_NS = 5000;
  localparam int QTR_CYC = (SCL_HALF_NS / 2 + CLK_NS - 1) / CLK_NS;
  localparam int DETECT_NS = 1000;
  localparam int DETECT_CYC = (DETECT_NS + CLK_NS - 1) / CLK_NS;
  localparam int STRETCH_NS = 100000;
  localparam int STRETCH_CYC = STRETCH_NS / CLK_NS;
  // bit-level commands
  typedef enum logic [1:0] {BC_START, BC_STOP, BC_WRITE, BC_READ} ssl_bcmd_t;
endpackage : ssl_pkg

// ---- shared/ssl_bit_if.sv ----
/*
  ssl_bit_if: link between the byte sequencer and the bit engine.
  Assumes both ends run on the same core clock.
*/
`timescale 1ns/10ps
interface ssl_bit_if;
  import ssl_pkg::*;
  logic req;
  ssl_bcmd_t cmd;
  logic wbit;
  logic abort;
  logic done;
  logic rx;
  logic fault;
  logic sda_s;
  logic scl_s;
  logic sda_lo;
  logic scl_lo;
  modport ctl (output req, cmd, wbit, abort, sda_s, scl_s, input done, rx, fault, sda_lo, scl_lo);
  modport eng (input req, cmd, wbit, abort, sda_s, scl_s, output done, rx, fault, sda_lo, scl_lo);
endinterface : ssl_bit_if

// ---- src/ssl_bit_engine.sv ----
/*
  ssl_bit_engine: plays one start, stop, write bit or read bit on the two-wire bus.
  Assumes synchronised line inputs and open-drain pads driven from sda_lo/scl_lo.
*/
`timescale 1ns/10ps
module ssl_bit_engine import ssl_pkg::*; #(
  parameter int QTR = QTR_CYC,
  parameter int STRETCH_MAX = STRETCH_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  ssl_bit_if.eng bus
);
  typedef enum logic {E_IDLE, E_RUN} ssl_est_t;

  ssl_est_t st_q, st_d;
  ssl_bcmd_t cmd_q, cmd_d;
  logic wbit_q, wbit_d;
  logic [1:0] ph_q, ph_d;
  logic [15:0] cnt_q, cnt_d;
  logic [17:0] stall_q, stall_d;
  logic sda_lo_q, sda_lo_d, scl_lo_q, scl_lo_d;
  logic rx_q, rx_d, done_q, done_d, fault_q, fault_d;

  // line levels per command and quarter: {scl low, sda low}
  // condition and bit shapes
  function automatic logic [1:0] lines(ssl_bcmd_t c, logic [1:0] p, logic b);
    logic [1:0] r;
    r = 2'b00;
    unique case (c)
      BC_START: r = (p == 2'd0) ? 2'b10 : (p == 2'd1) ? 2'b00 : (p == 2'd2) ? 2'b01 : 2'b11;
      BC_STOP: r = (p == 2'd0) ? 2'b11 : (p == 2'd1) ? 2'b01 : 2'b00;
      BC_WRITE: r = {(p == 2'd0) || (p == 2'd3), ~b};
      BC_READ: r = {(p == 2'd0) || (p == 2'd3), 1'b0};
    endcase
    return r;
  endfunction : lines

  // quarter sequencing with clock stretch wait
  always_comb begin
    st_d = st_q;
    cmd_d = cmd_q;
    wbit_d = wbit_q;
    ph_d = ph_q;
    cnt_d = cnt_q;
    stall_d = stall_q;
    sda_lo_d = sda_lo_q;
    scl_lo_d = scl_lo_q;
    rx_d = rx_q;
    done_d = 1'b0;
    fault_d = fault_q;
    if (bus.abort) begin
      st_d = E_IDLE;
      sda_lo_d = 1'b0;
      scl_lo_d = 1'b0;
    end else begin
      unique case (st_q)
        E_IDLE: if (bus.req) begin
          st_d = E_RUN;
          cmd_d = bus.cmd;
          wbit_d = bus.wbit;
          ph_d = 2'd0;
          cnt_d = '0;
          stall_d = '0;
          fault_d = 1'b0;
          {scl_lo_d, sda_lo_d} = lines(bus.cmd, 2'd0, bus.wbit);
        end
        E_RUN: begin
          if (ph_q != 2'd0 && ph_q != 2'd3 && !bus.scl_s && !scl_lo_q) begin
            // slave holds the clock low
            stall_d = stall_q + 18'd1;
            if (stall_q == 18'(STRETCH_MAX - 1)) begin
              fault_d = 1'b1;
              done_d = 1'b1;
              st_d = E_IDLE;
              sda_lo_d = 1'b0;
              scl_lo_d = 1'b0;
            end
          end else if (cnt_q == 16'(QTR - 1)) begin
            cnt_d = '0;
            // sample during the clock-high window
            if (ph_q == 2'd2) begin
              rx_d = bus.sda_s;
            end
            if (ph_q == 2'd3) begin
              st_d = E_IDLE;
              done_d = 1'b1;
            end else begin
              ph_d = ph_q + 2'd1;
              {scl_lo_d, sda_lo_d} = lines(cmd_q, ph_q + 2'd1, wbit_q);
            end
          end else begin
            cnt_d = cnt_q + 16'd1;
          end
        end
      endcase
    end
  end

  // engine registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q <= E_IDLE;
      cmd_q <= BC_STOP;
      wbit_q <= 1'b1;
      ph_q <= 2'd0;
      cnt_q <= '0;
      stall_q <= '0;
      sda_lo_q <= 1'b0;
      scl_lo_q <= 1'b0;
      rx_q <= 1'b1;
      done_q <= 1'b0;
      fault_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cmd_q <= cmd_d;
      wbit_q <= wbit_d;
      ph_q <= ph_d;
      cnt_q <= cnt_d;
      stall_q <= stall_d;
      sda_lo_q <= sda_lo_d;
      scl_lo_q <= scl_lo_d;
      rx_q <= rx_d;
      done_q <= done_d;
      fault_q <= fault_d;
    end
  end

  assign bus.sda_lo = sda_lo_q;
  assign bus.scl_lo = scl_lo_q;
  assign bus.rx = rx_q;
  assign bus.done = done_q;
  assign bus.fault = fault_q;
endmodule : ssl_bit_engine

// ---- src/ssl_loader.sv ----
/*
  ssl_loader: subsystem identity register with serial EEPROM load at reset,
  write-lock control and load status, reached through configuration accesses.
  Assumes pull-ups on SDA and SCL, pads that turn *_OE into a low drive,
  and configuration strobes on the core clock.
*/
//
// Behaviour
// - identity dword at 40h answers in function 0 and function 1
// - identity read-only unless write-lock bit 5 of 80h is cleared
// - after primary bus reset the identity loads from the EEPROM
// - suspend blocks primary and global reset from the core and loader
// - load only when a pull-up on the data line is seen
// - read four bytes from word address 00h with auto increment
// - byte at address 0 becomes the most significant byte
// - EEPROM is addressed as target 1010000b
// - idle bus leaves both lines released and pulled high
// - start drives data low, stop lets data rise with clock high
// - one bit per clock pulse, data steady while clock is high
// - after each sent byte release data, clock once, expect low ack
// - after each received byte drive data low on the ack clock
// - bit 2 of status at 85h shows the pull-up was seen
// - any load error such as missing ack sets bit 1
// - bit 0 of status is set throughout the load only
// - any undefined condition ends the load with the error bit
//
`timescale 1ns/10ps
module ssl_loader import ssl_pkg::*; #(
  parameter int QTR = QTR_CYC,
  parameter int DETECT = DETECT_CYC,
  parameter int STRETCH_MAX = STRETCH_CYC
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic PRIMARY_BUS_RESET_N,
  input wire logic GLOBAL_RESET_IN_N,
  input wire logic SUSPEND_N,
  input wire logic [2:0] CFG_FUNC,
  input wire logic [7:0] CFG_ADDR,
  input wire logic [3:0] CFG_BE,
  input wire logic CFG_WR,
  input wire logic CFG_RD,
  input wire logic [31:0] CFG_WDATA,
  output logic [31:0] CFG_RDATA,
  output logic CFG_RDVALID,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE,
  input wire logic SCL_IN,
  output logic SCL_OUT,
  output logic SCL_OE
);
  typedef enum logic [2:0] {S_DETECT, S_IDLE, S_ISSUE, S_WAIT, S_STOP} ssl_st_t;

  localparam int NSYNC = 5;

  ssl_bit_if bus ();

  logic [NSYNC-1:0] sync1_q, sync2_q;
  logic sda_s, scl_s, primary_bus_reset_s, global_reset_in_s, susp_s;
  logic core_rst;
  logic hit, wr_id, wr_ctl, rd_hit;

  ssl_st_t st_q, st_d;
  logic [3:0] step_q, step_d;
  logic [3:0] bit_q, bit_d;
  logic [31:0] shreg_q, shreg_d;
  logic [15:0] dcnt_q, dcnt_d;
  logic fail_q, fail_d;
  logic [31:0] ident_q, ident_d;
  logic [31:0] sysctl_q, sysctl_d;
  logic present_q, present_d;
  logic err_q, err_d;
  logic busy_q, busy_d;
  logic [31:0] rdata_q, rdata_d;
  logic rdvalid_q, rdvalid_d;

  // bit command for a step and bit slot
  function automatic ssl_bcmd_t op_cmd(logic [3:0] s, logic [3:0] b);
    ssl_bcmd_t c;
    c = BC_WRITE;
    if (s == STEP_START1 || s == STEP_START2) begin
      c = BC_START;
    end else if (s == STEP_STOP) begin
      c = BC_STOP;
    end else if (s >= STEP_DATA0) begin
      c = (b == ACK_SLOT) ? BC_WRITE : BC_READ;
    end else begin
      c = (b == ACK_SLOT) ? BC_READ : BC_WRITE;
    end
    return c;
  endfunction : op_cmd

  // bit value sent for a step and bit slot
  function automatic logic op_bit(logic [3:0] s, logic [3:0] b);
    logic [7:0] byt;
    byt = 8'h00;
    if (s == STEP_DEV_WR) begin
      byt = {EE_DEV_ADDR, 1'b0};
    end else if (s == STEP_DEV_RD) begin
      byt = {EE_DEV_ADDR, 1'b1};
    end else if (s == STEP_WORD) begin
      byt = EE_WORD_ADDR;
    end
    if (s >= STEP_DATA0 || b == ACK_SLOT) begin
      return 1'b0;
    end
    return byt[3'(7 - b)];
  endfunction : op_bit

  // two-stage synchronisers for pins
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      sync1_q <= 5'h1f;
      sync2_q <= 5'h1f;
    end else begin
      sync1_q <= {SDA_IN, SCL_IN, PRIMARY_BUS_RESET_N, GLOBAL_RESET_IN_N, SUSPEND_N};
      sync2_q <= sync1_q;
    end
  end

  assign {sda_s, scl_s, primary_bus_reset_s, global_reset_in_s, susp_s} = sync2_q;

  assign core_rst = susp_s && (!primary_bus_reset_s || !global_reset_in_s);

  assign hit = (CFG_FUNC <= 3'd1);
  assign wr_id = hit && CFG_WR && (CFG_ADDR == IDENT_OFS);
  assign wr_ctl = hit && CFG_WR && (CFG_ADDR == SYSCTL_OFS);
  assign rd_hit = hit && CFG_RD;

  // bit engine hookup
  assign bus.sda_s = sda_s;
  assign bus.scl_s = scl_s;
  assign bus.abort = core_rst;
  assign bus.req = (st_q == S_ISSUE);
  assign bus.cmd = op_cmd(step_q, bit_q);
  assign bus.wbit = op_bit(step_q, bit_q);

  ssl_bit_engine #(
    .QTR(QTR),
    .STRETCH_MAX(STRETCH_MAX)
  ) u_bits (
    .clk(CLK),
    .rst_n(RST_N),
    .bus(bus)
  );

  // load sequencer and register file next state
  always_comb begin
    st_d = st_q;
    step_d = step_q;
    bit_d = bit_q;
    shreg_d = shreg_q;
    dcnt_d = dcnt_q;
    fail_d = fail_q;
    ident_d = ident_q;
    sysctl_d = sysctl_q;
    present_d = present_q;
    err_d = err_q;
    busy_d = busy_q;
    rdvalid_d = rd_hit;
    rdata_d = rdata_q;
    // host side writes
    for (int i = 0; i < 4; i++) begin
      if (wr_id && !sysctl_q[LOCK_BIT] && CFG_BE[i]) begin
        ident_d[8*i +: 8] = CFG_WDATA[8*i +: 8];
      end
      if (wr_ctl && CFG_BE[i]) begin
        sysctl_d[8*i +: 8] = CFG_WDATA[8*i +: 8];
      end
    end
    if (core_rst) begin
      st_d = S_DETECT;
      dcnt_d = '0;
      ident_d = IDENT_RST;
      sysctl_d = SYSCTL_RST;
      present_d = 1'b0;
      err_d = 1'b0;
      busy_d = 1'b0;
      fail_d = 1'b0;
    end else begin
      unique case (st_q)
        S_DETECT: begin
          dcnt_d = dcnt_q + 16'd1;
          if (dcnt_q == 16'(DETECT - 1)) begin
            present_d = sda_s;
            if (sda_s) begin
              st_d = S_ISSUE;
              step_d = STEP_START1;
              bit_d = '0;
              fail_d = 1'b0;
              err_d = 1'b0;
              busy_d = 1'b1;
            end else begin
              st_d = S_IDLE;
            end
          end
        end
        S_IDLE: begin
          st_d = S_IDLE;
        end
        S_ISSUE: begin
          st_d = S_WAIT;
        end
        S_WAIT: if (bus.done) begin
          st_d = S_ISSUE;
          if (bus.fault && step_q != STEP_STOP) begin
            fail_d = 1'b1;
            step_d = STEP_STOP;
            bit_d = '0;
          end else if (step_q == STEP_STOP) begin
            st_d = S_IDLE;
            busy_d = 1'b0;
            if (fail_q || bus.fault) begin
              err_d = 1'b1;
            end else begin
              ident_d = shreg_q;
            end
          end else if (step_q == STEP_START1 || step_q == STEP_START2) begin
            step_d = step_q + 4'd1;
          end else if (bit_q != ACK_SLOT) begin
            bit_d = bit_q + 4'd1;
            if (step_q >= STEP_DATA0) begin
              shreg_d = {shreg_q[30:0], bus.rx};
            end
          end else begin
            bit_d = '0;
            if (step_q < STEP_DATA0 && bus.rx) begin
              fail_d = 1'b1;
              step_d = STEP_STOP;
            end else begin
              step_d = step_q + 4'd1;
            end
          end
        end
        default: begin
          st_d = S_ISSUE;
          step_d = STEP_STOP;
          bit_d = '0;
          fail_d = 1'b1;
        end
      endcase
    end
    // read data mux
    if (rd_hit) begin
      rdata_d = 32'h0000_0000;
      if (CFG_ADDR == IDENT_OFS) begin
        rdata_d = ident_q;
      end else if (CFG_ADDR == SYSCTL_OFS) begin
        rdata_d = sysctl_q;
      end else if (CFG_ADDR == STATUS_DW_OFS) begin
        rdata_d[8*STATUS_LANE +: 8] = {5'h00, present_q, err_q, busy_q};
      end
    end
  end

  // core registers
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      st_q <= S_DETECT;
      step_q <= STEP_START1;
      bit_q <= '0;
      shreg_q <= '0;
      dcnt_q <= '0;
      fail_q <= 1'b0;
      ident_q <= IDENT_RST;
      sysctl_q <= SYSCTL_RST;
      present_q <= 1'b0;
      err_q <= 1'b0;
      busy_q <= 1'b0;
      rdata_q <= '0;
      rdvalid_q <= 1'b0;
    end else begin
      st_q <= st_d;
      step_q <= step_d;
      bit_q <= bit_d;
      shreg_q <= shreg_d;
      dcnt_q <= dcnt_d;
      fail_q <= fail_d;
      ident_q <= ident_d;
      sysctl_q <= sysctl_d;
      present_q <= present_d;
      err_q <= err_d;
      busy_q <= busy_d;
      rdata_q <= rdata_d;
      rdvalid_q <= rdvalid_d;
    end
  end

  assign SDA_OUT = 1'b0;
  assign SCL_OUT = 1'b0;
  // engine changes data only with clock low, except for start and stop
  assign SDA_OE = bus.sda_lo;
  assign SCL_OE = bus.scl_lo;
  assign CFG_RDATA = rdata_q;
  assign CFG_RDVALID = rdvalid_q;
endmodule : ssl_loader

// ---- tb/ssl_loader_properties.sv ----
/* ssl_loader_properties: port checker for the identity loader.
   assumes it is bound into ssl_loader by the statement at the foot. */
`timescale 1ns/10ps
module ssl_loader_properties import ssl_pkg::*; #(
  parameter int QTR = QTR_CYC,
  parameter int DETECT = DETECT_CYC,
  parameter int STRETCH_MAX = STRETCH_CYC
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic [2:0] CFG_FUNC,
  input wire logic [7:0] CFG_ADDR,
  input wire logic CFG_RD,
  input wire logic [31:0] CFG_RDATA,
  input wire logic CFG_RDVALID,
  input wire logic SDA_IN,
  input wire logic SDA_OUT,
  input wire logic SDA_OE,
  input wire logic SCL_OUT,
  input wire logic SCL_OE
);
  logic nopull_q, nopull_d;
  logic [7:0] low_q, low_d;
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  // missing pull-up since reset, and cycles the clock line was released
  always_comb begin
    nopull_d = nopull_q && !SDA_IN;
    low_d = SCL_OE ? 8'h00 : low_q + 8'(low_q != 8'hff);
  end
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      nopull_q <= 1'b1;
      low_q <= 8'hff;
    end else begin
      nopull_q <= nopull_d;
      low_q <= low_d;
    end
  end
  sequence s_rd_ok;
    CFG_RD && CFG_FUNC <= 3'h1;
  endsequence
  sequence s_status_rd;
    CFG_RDVALID && $past(CFG_ADDR) == STATUS_DW_OFS;
  endsequence
  read_answer_a: assert property (s_rd_ok |=> CFG_RDVALID) else $error("read not answered");
  func_ignore_a: assert property (CFG_RD && CFG_FUNC > 3'h1 |=> !CFG_RDVALID) else $error("bad function answered");
  valid_cause_a: assert property (CFG_RDVALID |-> $past(CFG_RD)) else $error("stray read valid");
  open_drain_a: assert property (SDA_OUT == 1'b0 && SCL_OUT == 1'b0) else $error("line driven high");
  reset_idle_a: assert property ($rose(RST_N) |-> (!SDA_OE && !SCL_OE) [*4]) else $error("lines not released");
  no_pullup_a: assert property (nopull_q |-> !SCL_OE && !SDA_OE) else $error("transfer without pull-up");
  busy_shown_a: assert property (s_status_rd ##0 ($past(SCL_OE) && $past(SCL_OE, 2)) |-> CFG_RDATA[8 + BUSY_BIT])
    else $error("busy clear during transfer");
  scl_high_a: assert property ($rose(SCL_OE) |-> int'(low_q) >= 2 * QTR) else $error("clock high too short");
endmodule : ssl_loader_properties

bind ssl_loader ssl_loader_properties #(.QTR(QTR), .DETECT(DETECT), .STRETCH_MAX(STRETCH_MAX)) u_props (
  .CLK(CLK), .RST_N(RST_N), .CFG_FUNC(CFG_FUNC), .CFG_ADDR(CFG_ADDR), .CFG_RD(CFG_RD),
  .CFG_RDATA(CFG_RDATA), .CFG_RDVALID(CFG_RDVALID), .SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT),
  .SDA_OE(SDA_OE), .SCL_OUT(SCL_OUT), .SCL_OE(SCL_OE));

// ---- tb/ssl_eeprom_model.sv ----
/* ssl_eeprom_model: two-wire EEPROM holding four identity bytes.
   assumes wired-and lines with pull-ups built by the bench. */
`timescale 1ns/10ps
module ssl_eeprom_model (
  input wire logic clk,
  input wire logic scl,
  input wire logic sda,
  input wire logic [31:0] content,
  input wire logic nack_en,
  input wire logic [7:0] stretch,
  input wire logic clr,
  output logic sda_lo,
  output logic scl_lo,
  output logic [7:0] word_seen,
  output logic [3:0] dev_ok_n,
  output logic [3:0] mack_n
);
  logic scl_q, sda_q, act, rd, first;
  logic [3:0] cnt;
  logic [7:0] sh, st, cur;
  logic [1:0] ptr;
  assign cur = content[8 * (3 - int'(ptr)) +: 8];
  initial begin
    {scl_q, sda_q, act, rd, first, sda_lo, scl_lo} = 7'h7f & 7'h60;
    {cnt, sh, st, ptr, word_seen, dev_ok_n, mack_n} = '0;
  end
  // lines released by default, data moved only while clock low
  always @(posedge clk) begin
    scl_q <= scl;
    sda_q <= sda;
    if (clr) begin
      dev_ok_n <= 4'h0;
      mack_n <= 4'h0;
    end
    if (st != 8'h00) st <= st - 8'h01;
    else scl_lo <= 1'b0;
    if (scl && scl_q && sda_q && !sda) begin
      {act, first, rd, cnt, sda_lo} <= {3'b110, 4'h0, 1'b0};
    end else if (scl && scl_q && !sda_q && sda) begin
      {act, sda_lo} <= 2'b00;
    end else if (act && scl && !scl_q) begin
      if (cnt < 4'h8) {sh, cnt} <= {sh[6:0], sda, cnt + 4'h1};
      else begin
        cnt <= 4'h9;
        if (rd && !sda && !sda_lo) mack_n <= mack_n + 4'h1; // own address ack is not a master ack
      end
    end else if (act && !scl && scl_q) begin
      if (stretch != 8'h00) {scl_lo, st} <= {1'b1, stretch};
      if (cnt == 4'h8) begin
        if (first) begin
          {sda_lo, act} <= {2{sh[7:1] == 7'h50 && !nack_en}};
          {rd, first} <= {sh[0], 1'b0};
          if (sh[7:1] == 7'h50 && !nack_en) dev_ok_n <= dev_ok_n + 4'h1;
        end else if (rd) begin
          {sda_lo, ptr} <= {1'b0, ptr + 2'h1};
        end else begin
          // word address sets the auto-incrementing pointer
          {ptr, word_seen, sda_lo} <= {sh[1:0], sh, !nack_en};
        end
      end else if (cnt == 4'h9) begin
        {cnt, sda_lo} <= {4'h0, rd & ~cur[7]};
      end else if (rd) sda_lo <= ~cur[4'h7 - cnt];
    end
  end
endmodule : ssl_eeprom_model

// ---- tb/test_ssl_loader.sv ----
/* test_ssl_loader: scenarios for the identity loader and its EEPROM.
   assumes the checker is bound in and a 40 MHz core clock. */
`timescale 1ns/10ps
module test_ssl_loader;
  import ssl_pkg::*;
  localparam logic [31:0] C1 = 32'h9a3c5e71;
  localparam logic [31:0] C2 = 32'hb1e2d384;
  logic clk, rst_n, primary_bus_reset_n, global_reset_in_n, susp_n, wr, rd, rdv, sda_oe, scl_oe, ee_sda, ee_scl, pull_en, nack, clr;
  logic [2:0] func;
  logic [7:0] addr, word_seen, stretch;
  logic [3:0] be, dev_ok_n, mack_n;
  logic [31:0] wdata, rdata, content;
  int err_total, tests_run;
  wire sda_w = pull_en ? !(sda_oe | ee_sda) : 1'b0;
  wire scl_w = !(scl_oe | ee_scl);
  ssl_loader #(.QTR(4), .DETECT(4), .STRETCH_MAX(64)) u_dut (.CLK(clk), .RST_N(rst_n),
    .PRIMARY_BUS_RESET_N(primary_bus_reset_n), .GLOBAL_RESET_IN_N(global_reset_in_n), .SUSPEND_N(susp_n), .CFG_FUNC(func),
    .CFG_ADDR(addr), .CFG_BE(be), .CFG_WR(wr), .CFG_RD(rd), .CFG_WDATA(wdata), .CFG_RDATA(rdata),
    .CFG_RDVALID(rdv), .SDA_IN(sda_w), .SDA_OUT(), .SDA_OE(sda_oe), .SCL_IN(scl_w), .SCL_OUT(), .SCL_OE(scl_oe));
  ssl_eeprom_model u_ee (.clk(clk), .scl(scl_w), .sda(sda_w), .content(content), .nack_en(nack),
    .stretch(stretch), .clr(clr), .sda_lo(ee_sda), .scl_lo(ee_scl), .word_seen(word_seen),
    .dev_ok_n(dev_ok_n), .mack_n(mack_n));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic print_verdict();
    $display("checks %0d errors %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : print_verdict
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic cfg_wr(input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
    @(posedge clk);
    #2 {func, addr, be, wdata, wr} = {3'h0, a, b, d, 1'b1};
    @(posedge clk);
    #2 wr = 1'b0;
  endtask : cfg_wr
  task automatic cfg_rd(input logic [2:0] f, input logic [7:0] a, output logic [31:0] d, output logic v);
    @(posedge clk);
    #2 {func, addr, rd} = {f, a, 1'b1};
    @(posedge clk);
    #2 rd = 1'b0;
    {v, d} = {rdv, rdata};
  endtask : cfg_rd
  task automatic rd_chk(input string w, input logic [2:0] f, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic v;
    cfg_rd(f, a, d, v);
    chk(w, {31'h0, v}, 32'h1);
    chk(w, d, exp);
  endtask : rd_chk
  task automatic st_chk(input logic [2:0] exp);
    rd_chk("status", 3'h0, STATUS_DW_OFS, 32'(exp) << 8);
  endtask : st_chk
  task automatic wait_done(output logic busy_seen);
    logic [31:0] d;
    logic v;
    busy_seen = 1'b0;
    repeat (12) @(posedge clk);
    for (int i = 0; i <= 4000; i++) begin
      if (i == 4000) begin
        err_total++;
        print_verdict();
      end
      cfg_rd(3'h0, STATUS_DW_OFS, d, v);
      busy_seen |= d[8 + BUSY_BIT];
      if (d[8 + BUSY_BIT] === 1'b0 && i > 20) break;
    end
  endtask : wait_done
  task automatic bus_reset(input logic glob, input logic exp_busy);
    logic b;
    @(posedge clk);
    #2 {primary_bus_reset_n, global_reset_in_n, clr} = {glob, !glob, 1'b1};
    repeat (4) @(posedge clk);
    #2 {primary_bus_reset_n, global_reset_in_n, clr} = 3'b110;
    wait_done(b);
    chk("busy seen", 32'(b), 32'(exp_busy));
  endtask : bus_reset
  task automatic t_first_load();
    logic b;
    logic [31:0] d;
    logic v;
    wait_done(b);
    chk("busy seen", 32'(b), 32'h1);
    rd_chk("ident f0", 3'h0, IDENT_OFS, C1);
    rd_chk("ident f1", 3'h1, IDENT_OFS, C1);
    cfg_rd(3'h2, IDENT_OFS, d, v);
    chk("func2 valid", 32'(v), 32'h0);
    st_chk(3'b100);
    chk("word address", 32'(word_seen), 32'(EE_WORD_ADDR));
    chk("device acks", 32'(dev_ok_n), 32'h2);
    chk("master acks", 32'(mack_n), 32'(EE_BYTES));
    chk("idle lines", {30'h0, sda_w, scl_w}, 32'h3);
  endtask : t_first_load
  task automatic t_lock();
    rd_chk("sysctl reset", 3'h0, SYSCTL_OFS, SYSCTL_RST);
    cfg_wr(IDENT_OFS, 4'hf, 32'h12345678);
    rd_chk("ident locked", 3'h0, IDENT_OFS, C1);
    cfg_wr(SYSCTL_OFS, 4'h1, 32'h0);
    cfg_wr(IDENT_OFS, 4'h3, 32'h12345678);
    rd_chk("ident open", 3'h0, IDENT_OFS, {C1[31:16], 16'h5678});
    cfg_wr(SYSCTL_OFS, 4'h1, SYSCTL_RST);
    cfg_wr(IDENT_OFS, 4'hf, 32'h0);
    rd_chk("ident relocked", 3'h0, IDENT_OFS, {C1[31:16], 16'h5678});
    cfg_wr(STATUS_DW_OFS, 4'hf, 32'hffffffff);
    st_chk(3'b100);
    rd_chk("unmapped", 3'h0, 8'hf0, 32'h0);
  endtask : t_lock
  task automatic t_faults();
    nack = 1'b1;
    bus_reset(1'b0, 1'b1);
    st_chk(3'b110);
    rd_chk("ident kept", 3'h0, IDENT_OFS, IDENT_RST);
    nack = 1'b0;
    stretch = 8'd200;
    bus_reset(1'b1, 1'b1);
    st_chk(3'b110);
    repeat (250) @(posedge clk);
    chk("released", {30'h0, sda_w, scl_w}, 32'h3);
    {stretch, content} = {8'd20, C2};
    bus_reset(1'b1, 1'b1);
    rd_chk("slow load", 3'h0, IDENT_OFS, C2);
    st_chk(3'b100);
  endtask : t_faults
  task automatic t_suspend();
    susp_n = 1'b0;
    content = C1;
    repeat (3) @(posedge clk);
    bus_reset(1'b0, 1'b0);
    bus_reset(1'b1, 1'b0);
    rd_chk("suspended", 3'h0, IDENT_OFS, C2);
    susp_n = 1'b1;
  endtask : t_suspend
  task automatic t_nopull();
    logic b;
    pull_en = 1'b0;
    rst_n = 1'b0;
    repeat (6) @(posedge clk);
    #2 rst_n = 1'b1;
    wait_done(b);
    chk("busy seen", 32'(b), 32'h0);
    st_chk(3'b000);
    rd_chk("no load", 3'h0, IDENT_OFS, IDENT_RST);
  endtask : t_nopull
  initial begin
    {rst_n, primary_bus_reset_n, global_reset_in_n, susp_n, wr, rd, pull_en, nack, clr} = 9'b011100100;
    {func, addr, be, wdata, stretch, content} = {3'h0, 8'h0, 4'h0, 32'h0, 8'h0, C1};
    {err_total, tests_run} = '0;
    repeat (6) @(posedge clk);
    #2 rst_n = 1'b1;
    t_first_load();
    t_lock();
    t_faults();
    t_suspend();
    t_nopull();
    print_verdict();
  end
endmodule : test_ssl_loader
